/* File: logic/clock_gate_regs.svh */
`ifndef CLOCK_GATE_REGS_SVH
`define CLOCK_GATE_REGS_SVH
`define SYSCTL_BASE 32'h400FE000
`define RUN_GATE_OFFSET 12'h104
`define SLEEP_GATE_OFFSET 12'h114
`define DEEP_GATE_OFFSET 12'h124
`define CLOCK_CONFIG_OFFSET 12'h060
`define IRQ_STATUS_OFFSET 12'h200
`define IRQ_MASK_OFFSET 12'h204
`define ADDR_LOW_BITS 12
`define GATE_RESET 32'h00000000
`define GATE_WRITE_MASK 32'h00031037
`define CONFIG_WRITE_MASK 32'h08000000
`define CONFIG_RESET 32'h00000000
`define AUTO_GATE_BIT 27
`define IRQ_WRITE_MASK 32'h00000001
`define IRQ_FAULT_BIT 0
`define UNIT_COUNT 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define GP_COUNTER1_GATE_BIT 17
`define GP_COUNTER0_GATE_BIT 16
`define TWO_WIRE0_GATE_BIT 12
`define SYNC_SERIAL1_GATE_BIT 5
`define SYNC_SERIAL0_GATE_BIT 4
`define ASYNC_SERIAL2_GATE_BIT 2
`define ASYNC_SERIAL1_GATE_BIT 1
`define ASYNC_SERIAL0_GATE_BIT 0
`endif

/* File: logic/clock_gate_pkg.sv */
package clock_gate_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DEEP = 2'h3
  } power_mode_t;
  typedef struct packed {
    logic [31:0] addr;
    logic valid;
    logic write;
  } unit_access_t;
  typedef struct packed {
    logic fault;
    logic pass;
  } unit_answer_t;
endpackage

/* File: logic/peripheral_clock_gating.sv */
`timescale 1ns/10ps
`include "clock_gate_regs.svh"
// How it works
// - set bit clocks unit, clear stops it
// - access to gated-off unit gets fault
// - gate register resets to all zeros
// - run gate register at offset 0x104
// - run, sleep, deep registers per mode
// - sleep registers used only with auto gating
// - bits 17,16 gate counter modules 1,0
// - bit 12 gates two-wire module 0
// - bits 5,4 gate sync serial 1,0
// - bits 2,1,0 gate async ports 2,1,0
// - reserved bits read zero, ignore writes
module peripheral_clock_gating #(
  parameter int UNITS = `UNIT_COUNT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire clock_gate_pkg::power_mode_t power_mode,
  input wire clock_gate_pkg::unit_access_t [UNITS-1:0] unit_access,
  output clock_gate_pkg::unit_answer_t [UNITS-1:0] unit_answer,
  output logic [UNITS-1:0] unit_clk,
  output logic [UNITS-1:0] unit_enable,
  output logic irq
);
  import clock_gate_pkg::*;

  // ----------------------------------------
  // unit to bit map
  // ----------------------------------------
  localparam int unsigned BIT_POS [8] = '{
    `GP_COUNTER1_GATE_BIT,
    `GP_COUNTER0_GATE_BIT,
    `TWO_WIRE0_GATE_BIT,
    `SYNC_SERIAL1_GATE_BIT,
    `SYNC_SERIAL0_GATE_BIT,
    `ASYNC_SERIAL2_GATE_BIT,
    `ASYNC_SERIAL1_GATE_BIT,
    `ASYNC_SERIAL0_GATE_BIT
  };

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] run_mode_clock_gate_1_r;
  logic [31:0] sleep_mode_clock_gate_1_r;
  logic [31:0] deep_sleep_clock_gate_1_r;
  logic [31:0] run_clock_configuration_r;
  logic [31:0] irq_status_r;
  logic [31:0] irq_mask_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] active_gate;
  logic [31:0] wr_mask;
  logic wr_fire;
  logic [11:0] wr_off;
  logic [11:0] rd_off;
  logic wr_hit;
  logic rd_hit;
  logic rd_fire;
  logic [31:0] rd_val;
  logic fault_event;
  logic auto_clock_gate_select;
  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic wr_cfg;
  logic wr_stat;
  logic wr_msk;

  assign auto_clock_gate_select = run_clock_configuration_r[`AUTO_GATE_BIT];

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  always_comb begin
    unique case (power_mode)
      MODE_RUN: begin
        active_gate = run_mode_clock_gate_1_r;
      end
      MODE_SLEEP: begin
        active_gate = auto_clock_gate_select ? sleep_mode_clock_gate_1_r
                                             : run_mode_clock_gate_1_r;
      end
      MODE_DEEP: begin
        active_gate = auto_clock_gate_select ? deep_sleep_clock_gate_1_r
                                             : run_mode_clock_gate_1_r;
      end
      default: begin
        active_gate = run_mode_clock_gate_1_r;
      end
    endcase
  end

  // ----------------------------------------
  // per-unit gating and fault
  // ----------------------------------------
  logic [UNITS-1:0] fault_vec;
  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : gen_unit
      logic en_latch;
      logic gate_on;
      assign gate_on = active_gate[BIT_POS[g]];
      always_latch begin
        if (!aclk) begin
          en_latch <= gate_on;
        end
      end
      assign unit_clk[g] = aclk & en_latch;
      assign unit_enable[g] = gate_on;
      assign fault_vec[g] = unit_access[g].valid & ~gate_on;
      assign unit_answer[g].fault = fault_vec[g];
      assign unit_answer[g].pass = unit_access[g].valid & gate_on;
    end
  endgenerate

  // ----------------------------------------
  // fault summary
  // ----------------------------------------
  assign fault_event = |fault_vec;

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  logic aw_have;
  logic w_have;
  logic [31:0] aw_cur;
  logic [31:0] w_cur;
  logic [3:0] s_cur;
  assign aw_have = aw_held_r | (s_axi_awvalid & s_axi_awready);
  assign w_have = w_held_r | (s_axi_wvalid & s_axi_wready);
  assign aw_cur = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign w_cur = w_held_r ? wdata_r : s_axi_wdata;
  assign s_cur = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_fire = aw_have & w_have;
  assign wr_off = aw_cur[`ADDR_LOW_BITS-1:0];
  assign wr_mask = {{8{s_cur[3]}}, {8{s_cur[2]}}, {8{s_cur[1]}}, {8{s_cur[0]}}};

  always_comb begin
    unique case (wr_off)
      `RUN_GATE_OFFSET: wr_hit = 1'b1;
      `SLEEP_GATE_OFFSET: wr_hit = 1'b1;
      `DEEP_GATE_OFFSET: wr_hit = 1'b1;
      `CLOCK_CONFIG_OFFSET: wr_hit = 1'b1;
      `IRQ_STATUS_OFFSET: wr_hit = 1'b1;
      `IRQ_MASK_OFFSET: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // ----------------------------------------
  // write selects
  // ----------------------------------------
  assign wr_run = wr_fire && (wr_off == `RUN_GATE_OFFSET);
  assign wr_sleep = wr_fire && (wr_off == `SLEEP_GATE_OFFSET);
  assign wr_deep = wr_fire && (wr_off == `DEEP_GATE_OFFSET);
  assign wr_cfg = wr_fire && (wr_off == `CLOCK_CONFIG_OFFSET);
  assign wr_stat = wr_fire && (wr_off == `IRQ_STATUS_OFFSET);
  assign wr_msk = wr_fire && (wr_off == `IRQ_MASK_OFFSET);

  // ----------------------------------------
  // write response
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // gate and config registers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [31:0] bm,
                                        input logic [31:0] wm);
    merge = ((old & ~bm) | (val & bm)) & wm;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_mode_clock_gate_1_r <= `GATE_RESET;
    end else if (wr_run) begin
      run_mode_clock_gate_1_r <= merge(run_mode_clock_gate_1_r, w_cur, wr_mask,
                                       `GATE_WRITE_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_mode_clock_gate_1_r <= `GATE_RESET;
    end else if (wr_sleep) begin
      sleep_mode_clock_gate_1_r <= merge(sleep_mode_clock_gate_1_r, w_cur, wr_mask,
                                         `GATE_WRITE_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deep_sleep_clock_gate_1_r <= `GATE_RESET;
    end else if (wr_deep) begin
      deep_sleep_clock_gate_1_r <= merge(deep_sleep_clock_gate_1_r, w_cur, wr_mask,
                                         `GATE_WRITE_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_clock_configuration_r <= `CONFIG_RESET;
    end else if (wr_cfg) begin
      run_clock_configuration_r <= merge(run_clock_configuration_r, w_cur, wr_mask,
                                         `CONFIG_WRITE_MASK);
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  logic [31:0] w1c;
  assign w1c = wr_stat ? (w_cur & wr_mask) : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= 32'h00000000;
    end else begin
      irq_status_r <= (irq_status_r & ~w1c & `IRQ_WRITE_MASK)
                      | ({31'h0, fault_event} << `IRQ_FAULT_BIT);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= 32'h00000000;
    end else if (wr_msk) begin
      irq_mask_r <= merge(irq_mask_r, w_cur, wr_mask, `IRQ_WRITE_MASK);
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_off = s_axi_araddr[`ADDR_LOW_BITS-1:0];

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_off)
      `RUN_GATE_OFFSET: begin
        rd_val = run_mode_clock_gate_1_r;
      end
      `SLEEP_GATE_OFFSET: begin
        rd_val = sleep_mode_clock_gate_1_r;
      end
      `DEEP_GATE_OFFSET: begin
        rd_val = deep_sleep_clock_gate_1_r;
      end
      `CLOCK_CONFIG_OFFSET: begin
        rd_val = run_clock_configuration_r;
      end
      `IRQ_STATUS_OFFSET: begin
        rd_val = irq_status_r;
      end
      `IRQ_MASK_OFFSET: begin
        rd_val = irq_mask_r;
      end
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: testbench/peripheral_clock_gating_asserts.sv */
`timescale 1ns/10ps
// ---
// port checks
// ---
module pcg_checker #(
  parameter int UNITS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire clock_gate_pkg::power_mode_t power_mode,
  input wire clock_gate_pkg::unit_access_t [UNITS-1:0] unit_access,
  input wire clock_gate_pkg::unit_answer_t [UNITS-1:0] unit_answer,
  input wire logic [UNITS-1:0] unit_enable
);
  import clock_gate_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RESET_ZERO: assert property ($rose(aresetn) |-> unit_enable == '0)
    else $error("gate set after reset");
  for (genvar g = 0; g < UNITS; g++) begin : per_unit
    AST_FAULT_OFF: assert property (
      unit_access[g].valid && !unit_enable[g] |-> unit_answer[g] == 2'h2)
      else $error("no fault");
    AST_PASS_ON: assert property (
      unit_access[g].valid && unit_enable[g] |-> unit_answer[g] == 2'h1)
      else $error("no pass");
  end
  AST_IRQ_STICKY: assert property (
    irq && !(s_axi_awvalid || s_axi_wvalid) |=> irq)
    else $error("irq dropped");
  AST_B_AFTER_WRITE: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write answer");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  AST_GATE_STABLE: assert property (
    !(s_axi_awvalid || s_axi_wvalid) ##1 $stable(power_mode) |-> $stable(unit_enable))
    else $error("gate moved");
endmodule
bind peripheral_clock_gating pcg_checker #(.UNITS(UNITS)) pcg_checker_inst (.*);

/* File: testbench/unit_side_model.sv */
`timescale 1ns/10ps
// ---
// unit bus side
// ---
module unit_side_model (
  input wire logic aclk,
  input wire logic req_on,
  input wire logic [2:0] req_unit,
  output clock_gate_pkg::unit_access_t [7:0] unit_access
);
  import clock_gate_pkg::*;
  initial unit_access = '0;
  always @(posedge aclk) begin
    for (int g = 0; g < 8; g++) begin
      unit_access[g].valid <= req_on && req_unit == g;
      unit_access[g].write <= g[0];
      if (!unit_access[g].valid) unit_access[g].addr <= ~unit_access[g].addr;
    end
  end
endmodule

/* File: testbench/peripheral_clock_gating_tb.sv */
`timescale 1ns/10ps
`include "clock_gate_regs.svh"
// ---
// bench
// ---
module peripheral_clock_gating_tb;
  import clock_gate_pkg::*;
  logic aclk = '0, aresetn = '0, req_on = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] req_unit = '0;
  logic [7:0] unit_clk, unit_enable;
  power_mode_t power_mode = MODE_RUN;
  unit_access_t [7:0] unit_access;
  unit_answer_t [7:0] unit_answer;
  int err_total = 0, n_tests = 0;
  peripheral_clock_gating #(.UNITS(8)) peripheral_clock_gating_inst (.*);
  unit_side_model unit_side_model_inst (.*);
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    logic fin;
    logic [31:0] rd;
    logic [1:0] rs;
    n = 0;
    fin = 1'b0;
    rd = '0;
    rs = '0;
    @(posedge aclk);
    s_axi_awaddr <= `SYSCTL_BASE + off;
    s_axi_araddr <= `SYSCTL_BASE + off;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    {s_axi_bready, s_axi_rready} <= {wr, !wr};
    do begin
      @(posedge aclk);
      fin = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_arready) s_axi_arvalid <= '0;
      n++;
    end while (!fin && n < 40);
    {s_axi_bready, s_axi_rready} <= '0;
    chk(fin, 32'h1);
    chk(rs, er);
    if (!wr) chk(rd, d);
  endtask
  task automatic poke(input logic [2:0] u, input logic [1:0] exp);
    @(posedge aclk);
    {req_on, req_unit} <= {1'h1, u};
    @(posedge aclk);
    @(negedge aclk);
    chk(unit_answer[u], exp);
    @(posedge aclk);
    req_on <= '0;
  endtask
  task automatic t_reset;
    bus(1'h0, 12'h104, 32'h0, 2'h0);
    chk(unit_enable, 32'h0);
    bus(1'h0, 12'h300, 32'h0, 2'h2);
  endtask
  task automatic t_bits;
    int pos[8] = '{17, 16, 12, 5, 4, 2, 1, 0};
    bus(1'h1, 12'h104, 32'hFFFFFFFF, 2'h0);
    bus(1'h0, 12'h104, 32'h00031037, 2'h0);
    for (int g = 0; g < 8; g++) begin
      bus(1'h1, 12'h104, 32'h1 << pos[g], 2'h0);
      @(negedge aclk);
      chk(unit_enable, 32'h1 << g);
    end
  endtask
  task automatic t_fault;
    poke(3'h5, 2'h2);
    @(negedge aclk);
    chk(irq, 32'h0);
    bus(1'h1, 12'h204, 32'h1, 2'h0);
    bus(1'h1, 12'h104, 32'h1000, 2'h0);
    poke(3'h5, 2'h2);
    poke(3'h2, 2'h1);
    @(negedge aclk);
    chk(irq, 32'h1);
    bus(1'h0, 12'h200, 32'h1, 2'h0);
    bus(1'h1, 12'h200, 32'h1, 2'h0);
    @(negedge aclk);
    chk(irq, 32'h0);
    @(posedge aclk);
    #5;
    chk(unit_clk, 32'h4);
  endtask
  task automatic t_strobe;
    bus(1'h1, 12'h104, 32'h0, 2'h0);
    s_axi_wstrb <= 4'h1;
    bus(1'h1, 12'h104, 32'hFFFFFFFF, 2'h0);
    bus(1'h0, 12'h104, 32'h00000037, 2'h0);
    s_axi_wstrb <= 4'h4;
    bus(1'h1, 12'h104, 32'hFFFFFFFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    bus(1'h0, 12'h104, 32'h00030037, 2'h0);
  endtask
  task automatic t_sleep;
    bus(1'h1, 12'h104, 32'h00031037, 2'h0);
    bus(1'h1, 12'h114, 32'h1, 2'h0);
    bus(1'h1, 12'h124, 32'h10000, 2'h0);
    power_mode <= MODE_SLEEP;
    @(negedge aclk);
    chk(unit_enable, 32'hFF);
    bus(1'h1, 12'h060, 32'h08000000, 2'h0);
    @(negedge aclk);
    chk(unit_enable, 32'h80);
    @(posedge aclk);
    power_mode <= MODE_DEEP;
    @(negedge aclk);
    chk(unit_enable, 32'h2);
  endtask
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_bits();
    t_fault();
    t_strobe();
    t_sleep();
    complete_run();
  end
endmodule
